/* File: pkg/ps2_link_pkg.sv */
package ps2_link_pkg;

  localparam int CHANNELS = 2;
  localparam int CH_KEYBOARD = 0;
  localparam int CH_POINTER = 1;

  // Clock rate and link times.
  localparam int CLK_FREQ_MHZ = 200;
  localparam int INHIBIT_TIME_US = 60;
  localparam int INHIBIT_CYCLES = INHIBIT_TIME_US * CLK_FREQ_MHZ;
  localparam int EDGE_TIMEOUT_US = 2000;
  localparam int EDGE_TIMEOUT_CYCLES = EDGE_TIMEOUT_US * CLK_FREQ_MHZ;
  localparam int TIMER_W = 20;

  // Register port: address bit 2 picks the channel, bits 1:0 the register.
  localparam int ADDR_W = 3;
  localparam int CH_SEL_BIT = 2;
  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_CONTROL = 2'h2;
  localparam logic [1:0] REG_INDICATORS = 2'h3;

  // Control register fields.
  localparam int CTRL_DISABLE = 0;
  localparam int CTRL_AUTO_RESEND = 1;
  localparam int CTRL_MODE_LSB = 2;
  localparam logic [7:0] CONTROL_RESET = 8'h0a;
  localparam logic [7:0] CONTROL_MASK = 8'h0f;

  // Status register fields.
  localparam int ST_RX_FULL = 0;
  localparam int ST_TX_BUSY = 1;
  localparam int ST_TX_DONE = 2;
  localparam int ST_TX_NACK = 3;
  localparam int ST_TIMEOUT = 4;
  localparam int ST_RX_ERROR = 5;
  localparam int ST_TX_REFUSED = 6;
  localparam int ST_RX_OVERRUN = 7;
  localparam logic [7:0] STATUS_W1C_MASK = 8'hfc;

  // Scan code sets.
  localparam logic [1:0] SCAN_MODE_1 = 2'h1;
  localparam logic [1:0] SCAN_MODE_2 = 2'h2;
  localparam logic [1:0] SCAN_MODE_3 = 2'h3;

  // Peripheral command codes.
  localparam logic [7:0] CMD_SET_INDICATORS = 8'hed;
  localparam logic [7:0] CMD_ECHO = 8'hee;
  localparam logic [7:0] CMD_SELECT_SCAN_SET = 8'hf0;
  localparam logic [7:0] CMD_READ_ID = 8'hf2;
  localparam logic [7:0] CMD_TYPEMATIC = 8'hf3;
  localparam logic [7:0] CMD_ENABLE = 8'hf4;
  localparam logic [7:0] CMD_RESEND = 8'hfe;
  localparam logic [7:0] CMD_RESET = 8'hff;
  localparam logic [7:0] NO_OPTION = 8'h00;
  localparam logic [7:0] TYPEMATIC_MASK = 8'h7f;
  localparam logic [2:0] INDICATORS_RESET = 3'h0;

  // Frame positions: start, eight data, parity, stop, then acknowledge.
  localparam logic [3:0] RX_LAST_BIT = 4'h9;
  localparam logic [3:0] TX_ACK_BIT = 4'ha;

  typedef struct packed {
    logic clk;
    logic data;
  } line_in_t;

  localparam line_in_t LINE_IDLE = 2'h3;

  typedef struct packed {
    logic clk_out;
    logic clk_oe;
    logic data_out;
    logic data_oe;
  } line_out_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RECV,
    ST_INHIBIT,
    ST_SEND,
    ST_HOLD
  } link_state_t;

endpackage : ps2_link_pkg

/* File: core/ps2_line_sampler.sv */
`timescale 1ns/1ps
`default_nettype none

// Brings the two link lines into the clock domain and marks clock falls.
module ps2_line_sampler (
  input wire logic clk,
  input wire logic reset,
  input wire ps2_link_pkg::line_in_t line,
  output ps2_link_pkg::line_in_t level,
  output logic clk_fall
);

  ps2_link_pkg::line_in_t meta;
  ps2_link_pkg::line_in_t sync;
  logic prev_clk;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta <= ps2_link_pkg::LINE_IDLE;
      sync <= ps2_link_pkg::LINE_IDLE;
      prev_clk <= 1'b1;
    end else begin
      meta <= line;
      sync <= meta;
      prev_clk <= sync.clk;
    end
  end

  // Only the second stage is looked at, so metastability stays in the first.
  assign level = sync;
  assign clk_fall = prev_clk & ~sync.clk;

endmodule : ps2_line_sampler

`default_nettype wire

/* File: core/ps2_host_link.sv */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// [R1] Hold the peripheral clock low at least 60 us before each command.
// [R2] A frame already coming in finishes before the controller starts sending.
// [R3] Start a send by pulling data low; the peripheral then clocks the start bit.
// [R4] Shift eight data bits out least significant first, one per clock.
// [R5] Follow the data with an odd parity bit.
// [R6] The peripheral pulls data low and clocks that back as acknowledge.
// [R7] After the stop bit, hold the clock low while the peripheral processes.
// [R8] Only the peripheral toggles the clock; the controller only holds it low.
// [R9] The peripheral answers a command with an acknowledge or a resend request.
// [R10] The keyboard channel raises interrupt line 1.
// [R11] The pointer channel works identically and raises interrupt line 12.
// [R12] Scan mode 1 is receive only; modes 2 and 3 are two-way; mode 2 default. Mode 1 refuses only software writes; hardware resends still go out.
// [R13] After EDh one option byte: bit 2 caps, bit 1 num, bit 0 scroll lock.
// [R14] An enabled peripheral echoes EEh with EEh.
// [R15] Codes EFh and F1h are not acknowledged.
// [R16] After F0h the option byte waits for the acknowledge; 01h-03h pick the mode.
// [R17] F2h stops scanning and returns two identification bytes.
// [R18] F3h option: bit 7 zero, bits 6:5 delay, bits 4:0 repeat period.
// [R19] F4h enables scanning, F5h defaults and halts, F6h defaults and scans.
// [R20] F7h to FDh clear the buffer and are valid only in mode 3.
// [R21] A bad frame from the peripheral makes the controller send FEh.
// [R22] FFh resets the peripheral, runs its self test and returns to mode 2.
// [R23] Release data high as stop bit, then release the clock afterwards.
// [R24] Abort and flag a timeout when expected clock edges stop coming.
module ps2_host_link #(
  parameter int unsigned INHIBIT_CYCLES = ps2_link_pkg::INHIBIT_CYCLES,
  parameter int unsigned EDGE_TIMEOUT_CYCLES = ps2_link_pkg::EDGE_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire ps2_link_pkg::reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire ps2_link_pkg::line_in_t [ps2_link_pkg::CHANNELS-1:0] line_in,
  output wire ps2_link_pkg::line_out_t [ps2_link_pkg::CHANNELS-1:0] line_out,
  output wire logic keyboard_interrupt_line,
  output wire logic pointer_interrupt_line
);

  localparam int TW = ps2_link_pkg::TIMER_W;
  localparam logic [TW-1:0] INHIBIT_LAST = TW'(INHIBIT_CYCLES - 1);
  localparam logic [TW-1:0] TIMEOUT_LAST = TW'(EDGE_TIMEOUT_CYCLES - 1);

  wire logic [ps2_link_pkg::CHANNELS-1:0][7:0] ch_rdata;
  wire logic [ps2_link_pkg::CHANNELS-1:0] ch_rx_full;
  wire logic [7:0] chosen_rdata;

  assign chosen_rdata = ch_rdata[reg_req.addr[ps2_link_pkg::CH_SEL_BIT]];

  // Read data stand only in the cycle after the strobe, zero otherwise.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_req.rd ? chosen_rdata : 8'h00;
    end
  end

  // The interrupt lines follow the received-byte flag of each channel.
  assign keyboard_interrupt_line = ch_rx_full[ps2_link_pkg::CH_KEYBOARD]; // [R10]
  assign pointer_interrupt_line = ch_rx_full[ps2_link_pkg::CH_POINTER]; // [R11]

  // Both channels share one body, so the pointer link behaves as the keyboard link.
  for (genvar i = 0; i < ps2_link_pkg::CHANNELS; i++) begin : g_chan // [R11]

    ps2_link_pkg::line_in_t level;
    logic clk_fall;
    ps2_link_pkg::link_state_t state;
    ps2_link_pkg::link_state_t next_state;
    logic [TW-1:0] timer;
    logic [TW-1:0] next_timer;
    logic [3:0] bit_cnt;
    logic [3:0] next_bit_cnt;
    logic [9:0] rx_shift;
    logic [7:0] rx_data;
    logic [7:0] tx_byte;
    logic [7:0] control;
    logic [7:0] sticky;
    logic [7:0] set_vec;
    logic [7:0] expect_opt;
    logic [2:0] indicators;
    logic rx_full;
    logic tx_pending;
    logic await_reply;

    ps2_line_sampler u_sampler (
      .clk(clk),
      .reset(reset),
      .line(line_in[i]),
      .level(level),
      .clk_fall(clk_fall)
    );

    // Register decode.
    wire logic sel = 32'(reg_req.addr[ps2_link_pkg::CH_SEL_BIT]) == i;
    wire logic [1:0] reg_idx = reg_req.addr[1:0];
    wire logic wr_data = sel & reg_req.wr & (reg_idx == ps2_link_pkg::REG_DATA);
    wire logic wr_status = sel & reg_req.wr & (reg_idx == ps2_link_pkg::REG_STATUS);
    wire logic wr_control = sel & reg_req.wr & (reg_idx == ps2_link_pkg::REG_CONTROL);
    wire logic rd_clears = sel & reg_req.rd & (reg_idx == ps2_link_pkg::REG_DATA);
    wire logic [7:0] w1c = wr_status ? (reg_req.wdata & ps2_link_pkg::STATUS_W1C_MASK) : 8'h00;

    wire logic disabled = control[ps2_link_pkg::CTRL_DISABLE];
    wire logic auto_resend = control[ps2_link_pkg::CTRL_AUTO_RESEND];
    wire logic [1:0] scan_mode = control[ps2_link_pkg::CTRL_MODE_LSB +: 2];

    wire logic timed_out = timer == TIMEOUT_LAST;
    wire logic inhibit_done = timer == INHIBIT_LAST;

    // Outgoing frame: start low, data from bit 0 up, odd parity, stop released.
    wire logic [10:0] tx_frame = {1'b1, ~^tx_byte, tx_byte, 1'b0}; // [R4] [R5] [R23]
    // In the hold state the count runs past the frame end; the send-state term masks that read.
    wire logic tx_level = tx_frame[bit_cnt];

    // Incoming frame: ten bits after the start bit, shifted in from the top.
    wire logic [9:0] rx_word = {level.data, rx_shift[9:1]};
    wire logic rx_ok = rx_word[9] & (^rx_word[8:0]);
    wire logic rx_start = (state == ps2_link_pkg::ST_IDLE) & clk_fall & ~level.data & ~disabled;
    wire logic rx_last = (state == ps2_link_pkg::ST_RECV) & clk_fall & (bit_cnt == ps2_link_pkg::RX_LAST_BIT);
    wire logic rx_good = rx_last & rx_ok;
    wire logic rx_bad = rx_last & ~rx_ok;
    wire logic rx_room = ~rx_full | rd_clears;

    // The acknowledge is the level sampled at the eleventh clock fall.
    wire logic ack_edge = (state == ps2_link_pkg::ST_SEND) & clk_fall & (bit_cnt == ps2_link_pkg::TX_ACK_BIT);
    wire logic tx_acked = ack_edge & ~level.data; // [R6]
    wire logic tx_nacked = ack_edge & level.data;
    wire logic link_active = (state == ps2_link_pkg::ST_RECV) | (state == ps2_link_pkg::ST_SEND);
    wire logic link_timeout = link_active & timed_out & ~clk_fall; // [R24]

    // A pending send only starts from idle, so an incoming frame runs to its end.
    wire logic tx_go = (state == ps2_link_pkg::ST_IDLE) & tx_pending & ~disabled & ~rx_start; // [R2]

    // Hardware resends have priority over a software write in the same cycle.
    wire logic resend_err = rx_bad & auto_resend & ~tx_pending; // [R21]
    wire logic resend_req = rx_good & (rx_word[7:0] == ps2_link_pkg::CMD_RESEND) & auto_resend & ~tx_pending; // [R9]
    wire logic hw_load = resend_err | resend_req;
    wire logic mode_rx_only = scan_mode == ps2_link_pkg::SCAN_MODE_1;
    wire logic refuse = wr_data & (tx_pending | hw_load | await_reply | mode_rx_only); // [R12] [R16]
    wire logic sw_load = wr_data & ~refuse;
    wire logic [7:0] sw_byte = (expect_opt == ps2_link_pkg::CMD_TYPEMATIC) ?
                               (reg_req.wdata & ps2_link_pkg::TYPEMATIC_MASK) : reg_req.wdata; // [R18]

    wire logic takes_option = (tx_byte == ps2_link_pkg::CMD_SET_INDICATORS) |
                              (tx_byte == ps2_link_pkg::CMD_SELECT_SCAN_SET) |
                              (tx_byte == ps2_link_pkg::CMD_TYPEMATIC);
    wire logic opt_done = tx_acked & (expect_opt != ps2_link_pkg::NO_OPTION);
    wire logic scan_set_valid = (tx_byte[7:2] == 6'h00) & (tx_byte[1:0] != 2'h0);
    wire logic set_mode = opt_done & (expect_opt == ps2_link_pkg::CMD_SELECT_SCAN_SET) & scan_set_valid; // [R16]
    wire logic reset_mode = tx_acked & ~opt_done & (tx_byte == ps2_link_pkg::CMD_RESET); // [R22]

    always_comb begin
      next_state = state;
      next_timer = timer + 1'b1;
      next_bit_cnt = bit_cnt;
      unique case (state)
        ps2_link_pkg::ST_IDLE: begin
          next_timer = '0;
          if (rx_start) begin
            next_state = ps2_link_pkg::ST_RECV;
            next_bit_cnt = 4'h0;
          end else if (tx_go) begin
            next_state = ps2_link_pkg::ST_INHIBIT; // [R1]
          end
        end
        ps2_link_pkg::ST_RECV: begin
          if (clk_fall) begin
            next_timer = '0;
            next_bit_cnt = bit_cnt + 4'h1;
            if (rx_last) begin
              next_state = ps2_link_pkg::ST_IDLE;
            end
          end else if (timed_out) begin
            next_state = ps2_link_pkg::ST_IDLE; // [R24]
          end
        end
        ps2_link_pkg::ST_INHIBIT: begin
          if (inhibit_done) begin
            next_state = ps2_link_pkg::ST_SEND; // [R3]
            next_timer = '0;
            next_bit_cnt = 4'h0;
          end
        end
        ps2_link_pkg::ST_SEND: begin
          if (clk_fall) begin
            next_timer = '0;
            next_bit_cnt = bit_cnt + 4'h1; // [R4]
            if (ack_edge) begin
              next_state = ps2_link_pkg::ST_HOLD; // [R7]
            end
          end else if (timed_out) begin
            next_state = ps2_link_pkg::ST_IDLE; // [R24]
          end
        end
        // The hold reuses the inhibit count, so the peripheral gets as long to digest the byte.
        ps2_link_pkg::ST_HOLD: begin
          if (inhibit_done) begin
            next_state = ps2_link_pkg::ST_IDLE; // [R23]
          end
        end
      endcase
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        state <= ps2_link_pkg::ST_IDLE;
        timer <= '0;
        bit_cnt <= 4'h0;
      end else begin
        state <= next_state;
        timer <= next_timer;
        bit_cnt <= next_bit_cnt;
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        rx_shift <= 10'h000;
      end else if ((state == ps2_link_pkg::ST_RECV) & clk_fall) begin
        rx_shift <= rx_word;
      end
    end

    // A new byte landing in the cycle of the read wins over the clear.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        rx_data <= 8'h00;
        rx_full <= 1'b0;
      end else if (rx_good & rx_room) begin
        rx_data <= rx_word[7:0];
        rx_full <= 1'b1;
      end else if (rd_clears) begin
        rx_full <= 1'b0;
      end
    end

    // On a resend request the last byte stays in place and goes out again.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        tx_byte <= 8'h00;
      end else if (resend_err) begin
        tx_byte <= ps2_link_pkg::CMD_RESEND; // [R21]
      end else if (sw_load) begin
        tx_byte <= sw_byte;
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        tx_pending <= 1'b0;
      end else if (hw_load | sw_load) begin
        tx_pending <= 1'b1;
      end else if (tx_acked | tx_nacked | ((state == ps2_link_pkg::ST_SEND) & link_timeout)) begin
        tx_pending <= 1'b0;
      end
    end

    // Commands that carry an option byte block further writes until a reply arrives.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        expect_opt <= ps2_link_pkg::NO_OPTION;
        await_reply <= 1'b0;
      end else begin
        if (opt_done) begin
          expect_opt <= ps2_link_pkg::NO_OPTION;
        end else if (tx_acked & takes_option) begin
          expect_opt <= tx_byte;
        end
        if (tx_acked & ~opt_done & takes_option) begin
          await_reply <= 1'b1; // [R16]
        end else if (rx_good | disabled) begin
          await_reply <= 1'b0;
        end
      end
    end

    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        indicators <= ps2_link_pkg::INDICATORS_RESET;
      end else if (opt_done & (expect_opt == ps2_link_pkg::CMD_SET_INDICATORS)) begin
        indicators <= tx_byte[2:0]; // [R13]
      end
    end

    // The scan mode follows acknowledged mode commands, over any software write.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        control <= ps2_link_pkg::CONTROL_RESET; // [R12]
      end else if (set_mode) begin
        control[ps2_link_pkg::CTRL_MODE_LSB +: 2] <= tx_byte[1:0]; // [R16]
      end else if (reset_mode) begin
        control[ps2_link_pkg::CTRL_MODE_LSB +: 2] <= ps2_link_pkg::SCAN_MODE_2; // [R22]
      end else if (wr_control) begin
        control <= reg_req.wdata & ps2_link_pkg::CONTROL_MASK;
      end
    end

    always_comb begin
      set_vec = 8'h00;
      set_vec[ps2_link_pkg::ST_TX_DONE] = tx_acked;
      set_vec[ps2_link_pkg::ST_TX_NACK] = tx_nacked;
      set_vec[ps2_link_pkg::ST_TIMEOUT] = link_timeout; // [R24]
      set_vec[ps2_link_pkg::ST_RX_ERROR] = rx_bad;
      set_vec[ps2_link_pkg::ST_TX_REFUSED] = refuse;
      set_vec[ps2_link_pkg::ST_RX_OVERRUN] = rx_good & ~rx_room;
    end

    // Set wins over a write-one-to-clear in the same cycle.
    always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
        sticky <= 8'h00;
      end else begin
        sticky <= (sticky & ~w1c) | set_vec;
      end
    end

    wire logic [7:0] status = sticky | (8'(tx_pending) << ps2_link_pkg::ST_TX_BUSY) |
                              (8'(rx_full) << ps2_link_pkg::ST_RX_FULL);

    assign ch_rdata[i] = (reg_idx == ps2_link_pkg::REG_DATA) ? rx_data :
                         (reg_idx == ps2_link_pkg::REG_STATUS) ? status :
                         (reg_idx == ps2_link_pkg::REG_CONTROL) ? control :
                         {5'h00, indicators};
    assign ch_rx_full[i] = rx_full;

    // The clock is only ever pulled low, never driven high or toggled.
    assign line_out[i].clk_out = 1'b0; // [R8]
    assign line_out[i].clk_oe = disabled | (state == ps2_link_pkg::ST_INHIBIT) |
                                (state == ps2_link_pkg::ST_HOLD); // [R1] [R7]
    assign line_out[i].data_out = 1'b0;
    assign line_out[i].data_oe = (state == ps2_link_pkg::ST_SEND) & ~tx_level; // [R3] [R23]

  end

endmodule : ps2_host_link

`default_nettype wire

/* File: test/ps2_link_monitor.sv */
`timescale 1ns/1ps
`default_nettype none

module ps2_link_monitor #(
  parameter int unsigned INHIBIT_CYCLES = 20,
  parameter int unsigned EDGE_TIMEOUT_CYCLES = 200
) (
  input wire logic clk,
  input wire logic reset,
  input wire ps2_link_pkg::reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire ps2_link_pkg::line_in_t [ps2_link_pkg::CHANNELS-1:0] line_in,
  input wire ps2_link_pkg::line_out_t [ps2_link_pkg::CHANNELS-1:0] line_out,
  input wire logic keyboard_interrupt_line,
  input wire logic pointer_interrupt_line
);
  int unsigned inh_cnt;
  int unsigned dat_cnt;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      inh_cnt <= 0;
      dat_cnt <= 0;
    end else begin
      inh_cnt <= line_out[0].clk_oe ? inh_cnt + 1 : 0;
      dat_cnt <= line_out[0].data_oe ? dat_cnt + 1 : 0;
    end
  end

  default clocking @(posedge clk); endclocking
  default disable iff (reset);

  a_no_drive_high: assert property (line_out[0].clk_out == 1'b0 && line_out[0].data_out == 1'b0 &&
    line_out[1].clk_out == 1'b0 && line_out[1].data_out == 1'b0) else $error("link line driven high");
  a_inhibit_len: assert property ($fell(line_out[0].clk_oe) && line_out[0].data_oe
    |-> inh_cnt >= INHIBIT_CYCLES) else $error("inhibit too short before start bit");
  a_oe_exclusive: assert property (!(line_out[0].clk_oe && line_out[0].data_oe))
    else $error("clock and data pulled low together");
  a_stop_released: assert property ($rose(line_out[0].clk_oe)
    |-> !line_out[0].data_oe ##1 !line_out[0].data_oe) else $error("data held during clock hold");
  a_kbd_irq_clear: assert property ($fell(keyboard_interrupt_line)
    |-> $past(reg_req.rd && reg_req.addr == 3'h0)) else $error("keyboard interrupt dropped without read");
  a_ptr_irq_clear: assert property ($fell(pointer_interrupt_line)
    |-> $past(reg_req.rd && reg_req.addr == 3'h4)) else $error("pointer interrupt dropped without read");
  a_disable_clamp: assert property (reg_req.wr && reg_req.addr == 3'h2 && reg_req.wdata[0]
    |-> ##[1:3] line_out[0].clk_oe) else $error("disable did not clamp clock");
  a_data_bound: assert property (dat_cnt <= EDGE_TIMEOUT_CYCLES + 16)
    else $error("data held past edge timeout");
  a_rdata_quiet: assert property (!reg_req.rd |=> reg_rdata == 8'h00)
    else $error("read data outside read answer cycle");
endmodule : ps2_link_monitor

bind ps2_host_link ps2_link_monitor #(
  .INHIBIT_CYCLES(INHIBIT_CYCLES),
  .EDGE_TIMEOUT_CYCLES(EDGE_TIMEOUT_CYCLES)
) u_monitor (
  .clk(clk),
  .reset(reset),
  .reg_req(reg_req),
  .reg_rdata(reg_rdata),
  .line_in(line_in),
  .line_out(line_out),
  .keyboard_interrupt_line(keyboard_interrupt_line),
  .pointer_interrupt_line(pointer_interrupt_line)
);

`default_nettype wire

/* File: test/ps2_device_model.sv */
`timescale 1ns/1ps
`default_nettype none

module ps2_device_model (
  input wire logic clk_oe,
  input wire logic data_oe,
  output wire ps2_link_pkg::line_in_t line
);
  logic clk_low = 1'b0;
  logic data_low = 1'b0;
  logic mute = 1'b0;
  logic nack = 1'b0;
  logic reply = 1'b1;
  logic sending = 1'b0;
  logic [7:0] last = 8'h00;
  logic [9:0] got = 10'h000;
  int n_rx = 0;

  // Identification bytes returned on a read of the identity; the values are arbitrary.
  localparam logic [7:0] ID_FIRST = 8'h5c;
  localparam logic [7:0] ID_SECOND = 8'h3a;

  // Both lines have pull-ups, so a released line reads high, never a stale value.
  assign line.clk = !(clk_oe || clk_low);
  assign line.data = !(data_oe || data_low);

  task automatic send_byte(input logic [7:0] b, input logic bad);
    logic [10:0] f;
    sending = 1'b1;
    last = b;
    f = {1'b1, (~^b) ^ bad, b, 1'b0};
    wait (!clk_oe);
    #100;
    for (int i = 0; i < 11; i++) begin
      data_low = !f[i];
      #16;
      clk_low = 1'b1;
      #32;
      clk_low = 1'b0;
      #16;
    end
    data_low = 1'b0;
    sending = 1'b0;
  endtask : send_byte

  always @(negedge clk_oe) begin
    #1;
    if (data_oe && !mute) begin
      #20;
      for (int i = 0; i < 11; i++) begin
        clk_low = 1'b1;
        #32;
        clk_low = 1'b0;
        #16;
        if (i < 10) got[i] = line.data;
        if (i == 9) data_low = !nack;
        #16;
      end
      data_low = 1'b0;
      n_rx++;
      if (reply) begin
        if (^got[8:0] !== 1'b1) send_byte(8'hfe, 1'b0);
        else if (got[7:0] == 8'hfe) send_byte(last, 1'b0);
        else if (got[7:0] == 8'hee) send_byte(8'hee, 1'b0);
        else if (got[7:0] == 8'hf2) begin
          send_byte(8'hfa, 1'b0);
          send_byte(ID_FIRST, 1'b0);
          send_byte(ID_SECOND, 1'b0);
        end else if (got[7:0] != 8'hef && got[7:0] != 8'hf1) send_byte(8'hfa, 1'b0);
      end
    end
  end
endmodule : ps2_device_model

`default_nettype wire

/* File: test/ps2_host_link_bench.sv */
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module ps2_host_link_bench;
  logic clk = 1'b0;
  logic reset = 1'b1;
  ps2_link_pkg::reg_req_t req = '0;
  logic [7:0] rdata;
  logic [7:0] v;
  wire ps2_link_pkg::line_in_t [ps2_link_pkg::CHANNELS-1:0] lin;
  wire ps2_link_pkg::line_out_t [ps2_link_pkg::CHANNELS-1:0] lout;
  wire logic kbd_irq;
  wire logic ptr_irq;
  int err_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;

  ps2_host_link #(.INHIBIT_CYCLES(20), .EDGE_TIMEOUT_CYCLES(200)) u_dut (
    .clk(clk), .reset(reset), .reg_req(req), .reg_rdata(rdata), .line_in(lin), .line_out(lout),
    .keyboard_interrupt_line(kbd_irq), .pointer_interrupt_line(ptr_irq));
  ps2_device_model u_kbd (.clk_oe(lout[0].clk_oe), .data_oe(lout[0].data_oe), .line(lin[0]));
  ps2_device_model u_ptr (.clk_oe(lout[1].clk_oe), .data_oe(lout[1].data_oe), .line(lin[1]));

  initial forever #2.5 clk = ~clk;

  task automatic final_report();
    if (err_count == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_count++;
      final_report();
    end
  end

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic expect_rd(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    v = rdata;
    `CHK(v & m, e)
  endtask : expect_rd

  // Waits for a host frame to land and for any model reply to finish.
  task automatic wait_rx(input int k);
    for (int i = 0; i < 4000 && (u_kbd.n_rx == k || u_kbd.sending); i++) @(posedge clk);
    #1;
  endtask : wait_rx

  task automatic wait_irq(input bit p);
    for (int i = 0; i < 4000 && !(p ? ptr_irq : kbd_irq); i++) @(posedge clk);
  endtask : wait_irq

  task automatic cmd(input logic [7:0] b, input logic [7:0] e, input logic [7:0] answer);
    n = u_kbd.n_rx;
    wr(3'h0, b);
    wait_rx(n);
    `CHK(u_kbd.got, {1'b1, ~^e, e})
    wait_irq(1'b0);
    expect_rd(3'h0, 8'hff, answer);
  endtask : cmd

  initial begin
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    expect_rd(3'h2, 8'hff, 8'h0a);
    expect_rd(3'h1, 8'hff, 8'h00);
    expect_rd(3'h3, 8'hff, 8'h00);
    u_ptr.send_byte(8'h5a, 1'b0);
    wait_irq(1'b1);
    `CHK({kbd_irq, ptr_irq}, 2'b01)
    expect_rd(3'h4, 8'hff, 8'h5a);
    cmd(ps2_link_pkg::CMD_SET_INDICATORS, 8'hed, 8'hfa);
    expect_rd(3'h1, 8'h0e, 8'h04);
    cmd(8'hfd, 8'hfd, 8'hfa);
    expect_rd(3'h3, 8'hff, 8'h05);
    cmd(ps2_link_pkg::CMD_ECHO, 8'hee, 8'hee);
    cmd(ps2_link_pkg::CMD_TYPEMATIC, 8'hf3, 8'hfa);
    cmd(8'hff, 8'h7f, 8'hfa);
    cmd(ps2_link_pkg::CMD_SELECT_SCAN_SET, 8'hf0, 8'hfa);
    cmd(8'h03, 8'h03, 8'hfa);
    expect_rd(3'h2, 8'h0c, 8'h0c);
    cmd(ps2_link_pkg::CMD_RESET, 8'hff, 8'hfa);
    expect_rd(3'h2, 8'h0c, 8'h08);
    // Scan mode 1 is receive only, so the write must bounce.
    wr(3'h2, 8'h06);
    wr(3'h1, 8'hfc);
    n = u_kbd.n_rx;
    wr(3'h0, 8'h11);
    expect_rd(3'h1, 8'h42, 8'h40);
    // Long enough for a send that slipped through to reach the peripheral.
    repeat (200) @(posedge clk);
    `CHK(u_kbd.n_rx, n)
    wr(3'h2, 8'h0a);
    u_kbd.nack = 1'b1;
    u_kbd.reply = 1'b0;
    wr(3'h1, 8'hfc);
    n = u_kbd.n_rx;
    wr(3'h0, 8'h55);
    wait_rx(n);
    `CHK(lout[0].clk_oe, 1'b1)
    expect_rd(3'h1, 8'h0e, 8'h08);
    u_kbd.nack = 1'b0;
    u_kbd.reply = 1'b1;
    wr(3'h1, 8'hfc);
    n = u_kbd.n_rx;
    u_kbd.send_byte(8'h3c, 1'b1);
    wait_rx(n);
    `CHK(u_kbd.got[7:0], ps2_link_pkg::CMD_RESEND)
    expect_rd(3'h1, 8'h21, 8'h21);
    expect_rd(3'h0, 8'hff, 8'h3c);
    n = u_kbd.n_rx;
    fork
      u_kbd.send_byte(8'h96, 1'b0);
      begin
        repeat (40) @(posedge clk);
        wr(3'h0, 8'h21);
      end
    join
    expect_rd(3'h0, 8'hff, 8'h96);
    wait_rx(n);
    `CHK(u_kbd.got[7:0], 8'h21)
    wait_irq(1'b0);
    expect_rd(3'h0, 8'hff, 8'hfa);
    // A silent peripheral must not hang the sender.
    u_kbd.mute = 1'b1;
    wr(3'h1, 8'hfc);
    wr(3'h0, 8'h33);
    repeat (300) @(posedge clk);
    expect_rd(3'h1, 8'h12, 8'h10);
    u_kbd.mute = 1'b0;
    wr(3'h2, 8'h0b);
    #1;
    `CHK(lout[0].clk_oe, 1'b1)
    wr(3'h2, 8'h0a);
    // A resend request repeats the last byte; its answer overruns the unread request.
    n = u_kbd.n_rx;
    u_kbd.send_byte(ps2_link_pkg::CMD_RESEND, 1'b0);
    wait_rx(n);
    `CHK(u_kbd.got[7:0], 8'h33)
    expect_rd(3'h1, 8'h81, 8'h81);
    expect_rd(3'h0, 8'hff, 8'hfe);
    final_report();
  end
endmodule : ps2_host_link_bench

`default_nettype wire
